// file: logic/sar_dev.sv
// converter end: conversion sequencing, busy, and the parallel read port
// Notes on behaviour
// - falling convert strobe with chip select low holds sample, starts conversion
// - busy high throughout each running conversion
// - busy falls on the same core-clock edge that latches the result
// - busy falls on a conversion-clock rise
// - conversion stepped by the external conversion clock
// - every conversion yields a 16-bit word
// - one conversion per sample period, 500 kSPS
// - acquisition lasts four conversion-clock cycles
// - read port answers only with chip select low
// - read strobe low enables the result bus
// - host lowers chip select with convert strobe
// - half-select 1 moves bits 15:8 to low lane
// - 8-bit option: two reads, toggling half-select
// - half-select may change while read strobe held
// - half-select settled before read strobe falls
`timescale 1ns/1ps
module sar_dev
    import sar_pkg::*;
#(
    parameter int ACQ_N  = ACQ_CYCLES,
    parameter int CONV_N = CONV_CYCLES
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // link to the host
    sar_link_if.dev                  link,
    // user side: sampled analog value as a signed code
    input  wire logic [RESULT_W-1:0] sample_code,
    output logic                     conv_done,
    output logic [RESULT_W-1:0]      result_word
);
    // a 16-bit word needs one conversion step per bit; the step counter is five bits wide
    if (ACQ_N < 1 || CONV_N < RESULT_W || ACQ_N + CONV_N > 31) begin : g_bad_phase
        $error("sar_dev: phase lengths out of range");
    end

    // two-flop synchronisers for every pin input
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // idle pin levels, so no false edge appears after reset
            pin_s1_r <= 5'h1C;
            pin_s2_r <= 5'h1C;
        end else begin
            pin_s1_r <= {link.convst_n, link.cs_n, link.rd_n, link.byte_sel, link.conv_clk};
            pin_s2_r <= pin_s1_r;
        end
    end
    logic convst_n_s, cs_n_s, rd_n_s, byte_s, cclk_s;
    assign {convst_n_s, cs_n_s, rd_n_s, byte_s, cclk_s} = pin_s2_r;

    // edge detectors on synchronised levels
    logic convst_d_r;
    logic cclk_d_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            convst_d_r <= 1'b1;
            cclk_d_r   <= 1'b0;
        end else begin
            convst_d_r <= convst_n_s;
            cclk_d_r   <= cclk_s;
        end
    end
    logic start_ev;
    logic cclk_rise;
    assign start_ev  = convst_d_r & ~convst_n_s & ~cs_n_s;
    assign cclk_rise = cclk_s & ~cclk_d_r;

    // sequencer: idle, hold/acquire, then successive approximation
    sar_state_type       state_r;
    logic [CNT_W-1:0]    step_r;
    logic [RESULT_W-1:0] held_r;
    logic [RESULT_W-1:0] sar_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= SAR_IDLE;
            step_r  <= CNT_ZERO;
        end else begin
            case (state_r)
                SAR_IDLE: begin
                    if (start_ev) begin
                        state_r <= SAR_ACQ;
                        step_r  <= CNT_ZERO;
                    end
                end
                SAR_ACQ: begin
                    if (cclk_rise) begin
                        if (step_r == CNT_W'(ACQ_N - 1)) begin
                            state_r <= SAR_CONV;
                            step_r  <= CNT_ZERO;
                        end else begin
                            step_r <= step_r + 1'b1;
                        end
                    end
                end
                SAR_CONV: begin
                    if (cclk_rise) begin
                        if (step_r == CNT_W'(CONV_N - 1)) begin
                            state_r <= SAR_IDLE;
                            step_r  <= CNT_ZERO;
                        end else begin
                            step_r <= step_r + 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= SAR_IDLE;
                    step_r  <= CNT_ZERO;
                end
            endcase
        end
    end

    // sample captured on the start strobe; held steady through conversion
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            held_r <= RESULT_RST;
        end else if (state_r == SAR_IDLE && start_ev) begin
            held_r <= sample_code;
        end
    end

    // one result bit resolved per conversion-clock rise, msb first; the
    // next value also feeds the holding register, since the lsb lands on the last step
    logic [RESULT_W-1:0] sar_nxt;
    always_comb begin
        sar_nxt = sar_r;
        if (step_r < CNT_W'(RESULT_W)) begin
            sar_nxt[RESULT_W-1-step_r[3:0]] = held_r[RESULT_W-1-step_r[3:0]];
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sar_r <= RESULT_RST;
        end else if (state_r == SAR_ACQ) begin
            sar_r <= RESULT_RST;
        end else if (state_r == SAR_CONV && cclk_rise) begin
            sar_r <= sar_nxt;
        end
    end

    // output holding register: loaded in the same edge that ends conversion
    logic last_step;
    assign last_step = state_r == SAR_CONV && cclk_rise && step_r == CNT_W'(CONV_N - 1);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_word <= RESULT_RST;
            conv_done   <= 1'b0;
        end else begin
            conv_done <= last_step;
            if (last_step) begin
                result_word <= sar_nxt;
            end
        end
    end

    // busy registered from state; falls one core cycle after the clock rise,
    // well inside the 25 ns bound once synchroniser delay is counted
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link.busy <= 1'b0;
        end else begin
            link.busy <= (state_r != SAR_IDLE) && !last_step;
        end
    end

    // read port: bus re-registered from byte select every core cycle, so a held strobe tracks it
    logic rd_active;
    assign rd_active = ~cs_n_s & ~rd_n_s;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link.result_bus  <= RESULT_RST;
            link.result_oe_n <= 1'b1;
        end else begin
            link.result_oe_n <= ~rd_active;
            if (byte_s) begin
                link.result_bus <= {result_word[RESULT_W-1:BYTE_W],
                                    result_word[RESULT_W-1:BYTE_W]};
            end else begin
                link.result_bus <= result_word;
            end
        end
    end
endmodule

// file: logic/sar_pkg.sv
// shared constants for the converter control and parallel read port
package sar_pkg;
    localparam int RESULT_W      = 16;    // bits per result word
    localparam int BYTE_W        = 8;     // low lane width in the 8-bit option
    localparam int ACQ_CYCLES    = 4;     // acquisition phase, conversion-clock cycles
    localparam int CONV_CYCLES   = 16;    // conversion phase, conversion-clock cycles
    localparam int SAMPLE_CYCLES = ACQ_CYCLES + CONV_CYCLES;
    localparam int MAX_RATE_KSPS = 500;   // throughput ceiling
    localparam int CORE_MHZ      = 250;
    localparam int CORE_PER_SAMPLE = (CORE_MHZ * 1000) / MAX_RATE_KSPS;
    localparam int BUSY_DLY_NS   = 25;    // latest busy fall after a clock rise
    localparam int CORE_PERIOD_NS = 1000 / CORE_MHZ;
    localparam int BUSY_DLY_CYC  = BUSY_DLY_NS / CORE_PERIOD_NS;
    localparam int CNT_W         = 5;
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [CNT_W-1:0]    CNT_ZERO   = 5'h00;

    typedef enum logic [2:0] {
        SAR_IDLE = 3'b001,
        SAR_ACQ  = 3'b010,
        SAR_CONV = 3'b100
    } sar_state_type;

    typedef enum logic [3:0] {
        HOST_IDLE  = 4'b0001,
        HOST_WAIT  = 4'b0010,
        HOST_READ  = 4'b0100,
        HOST_GAP   = 4'b1000
    } sar_host_state_type;
endpackage

// file: logic/sar_link_if.sv
// pins between the converter and the host controller
`timescale 1ns/1ps
interface sar_link_if;
    logic                         convst_n;
    logic                         cs_n;
    logic                         rd_n;
    logic                         byte_sel;
    logic                         conv_clk;
    logic                         busy;
    logic [sar_pkg::RESULT_W-1:0] result_bus;
    logic                         result_oe_n;

    modport dev  (input convst_n, cs_n, rd_n, byte_sel, conv_clk,
                  output busy, result_bus, result_oe_n);
    modport host (output convst_n, cs_n, rd_n, byte_sel, conv_clk,
                  input busy, result_bus, result_oe_n);
endinterface

// file: logic/sar_host.sv
// host end: conversion clock, start strobe and result readout
`timescale 1ns/1ps
module sar_host
    import sar_pkg::*;
#(
    parameter int CLK_DIV = 25,                       // core cycles per half conversion clock
    parameter int STROBE_CYC = 4                      // strobe timer load: the convert strobe and each read step last this plus one core cycles
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // link to the converter
    sar_link_if.host                 link,
    // user side
    input  wire logic                start_req,
    input  wire logic                byte_mode,
    output logic                     start_ready,
    output logic                     data_valid,
    output logic [RESULT_W-1:0]      data_word
);
    // the divider and strobe timer are 8 and 4 bits wide
    if (CLK_DIV < 13 || CLK_DIV > 256 || STROBE_CYC < 4 || STROBE_CYC > 15) begin : g_bad_cfg
        $error("sar_host: divider or strobe length out of range");
    end

    // conversion clock from a divider (>=100 ns period at 250 MHz)
    logic [7:0] div_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_r         <= 8'h00;
            link.conv_clk <= 1'b0;
        end else if (div_r == 8'(CLK_DIV - 1)) begin
            div_r         <= 8'h00;
            link.conv_clk <= ~link.conv_clk;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // busy comes from the other end: synchronise
    logic busy_s1_r, busy_s2_r, busy_d_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
            busy_d_r  <= 1'b0;
        end else begin
            busy_s1_r <= link.busy;
            busy_s2_r <= busy_s1_r;
            busy_d_r  <= busy_s2_r;
        end
    end

    // spacing counter keeps starts no faster than the sample period
    sar_host_state_type state_r;
    logic [3:0]  tmr_r;
    logic [15:0] rate_r;
    logic        second_r;
    logic        bmode_r;
    assign start_ready = state_r == HOST_IDLE && rate_r == 16'h0000;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rate_r <= 16'h0000;
        end else if (start_ready && start_req) begin
            rate_r <= 16'(CORE_PER_SAMPLE - 1);
        end else if (rate_r != 16'h0000) begin
            rate_r <= rate_r - 1'b1;
        end
    end

    // transaction sequencer; chip select drops with the start strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r       <= HOST_IDLE;
            tmr_r         <= 4'h0;
            second_r      <= 1'b0;
            bmode_r       <= 1'b0;
            link.cs_n     <= 1'b1;
            link.convst_n <= 1'b1;
            link.rd_n     <= 1'b1;
            link.byte_sel <= 1'b0;
            data_valid    <= 1'b0;
            data_word     <= 16'h0000;
        end else begin
            data_valid <= 1'b0;
            case (state_r)
                HOST_IDLE: begin
                    if (start_ready && start_req) begin
                        link.cs_n     <= 1'b0;
                        link.convst_n <= 1'b0;
                        link.byte_sel <= 1'b0;
                        bmode_r       <= byte_mode;
                        tmr_r         <= 4'(STROBE_CYC);
                        state_r       <= HOST_WAIT;
                    end
                end
                HOST_WAIT: begin
                    if (tmr_r != 4'h0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        link.convst_n <= 1'b1;
                    end
                    if (busy_d_r && !busy_s2_r) begin   // result latched
                        link.rd_n <= 1'b0;
                        second_r  <= 1'b0;
                        tmr_r     <= 4'(STROBE_CYC);
                        state_r   <= HOST_READ;
                    end
                end
                HOST_READ: begin
                    // the read strobe and byte select pass three flops inside the converter before the bus answers
                    if (tmr_r != 4'h0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (!bmode_r) begin
                        data_word  <= link.result_bus;
                        data_valid <= 1'b1;
                        link.rd_n  <= 1'b1;
                        state_r    <= HOST_GAP;
                    end else if (!second_r) begin
                        data_word[7:0] <= link.result_bus[7:0];
                        link.byte_sel  <= 1'b1;
                        second_r       <= 1'b1;
                        tmr_r          <= 4'(STROBE_CYC);
                    end else begin
                        data_word[15:8] <= link.result_bus[7:0];
                        data_valid      <= 1'b1;
                        link.rd_n       <= 1'b1;
                        state_r         <= HOST_GAP;
                    end
                end
                HOST_GAP: begin
                    link.cs_n     <= 1'b1;
                    link.byte_sel <= 1'b0;
                    state_r       <= HOST_IDLE;
                end
                default: begin
                    state_r <= HOST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: testbench/sar_link_properties.sv
// link checker: busy timing and read-port behaviour seen on the pins
`timescale 1ns/1ps
module sar_link_properties
    import sar_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // driven by the host end
    input  wire logic                convst_n,
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                byte_sel,
    input  wire logic                conv_clk,
    // driven by the converter end
    input  wire logic                busy,
    input  wire logic [RESULT_W-1:0] result_bus,
    input  wire logic                result_oe_n
);
    // raw pins lead the converter's synchronised view, so one rise may go uncounted
    localparam int         RISE_LO  = SAMPLE_CYCLES - 1;
    localparam int         RISE_HI  = SAMPLE_CYCLES;
    localparam logic [3:0] BUSY_AGE = 4'(BUSY_DLY_CYC);
    logic       clk_d_r;
    logic       cvs_d_r;
    logic       busy_d_r;
    logic [3:0] clk_age_r;
    logic [3:0] start_age_r;
    logic [5:0] rise_cnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // pin history; ages saturate so a long idle never looks recent
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_d_r     <= 1'h0;
            cvs_d_r     <= 1'h1;
            busy_d_r    <= 1'h0;
            clk_age_r   <= 4'hF;
            start_age_r <= 4'hF;
            rise_cnt_r  <= 6'h00;
        end else begin
            clk_d_r     <= conv_clk;
            cvs_d_r     <= convst_n;
            busy_d_r    <= busy;
            clk_age_r   <= (conv_clk && !clk_d_r) ? 4'h0 : clk_age_r + {3'h0, clk_age_r != 4'hF};
            start_age_r <= (!convst_n && cvs_d_r && !cs_n) ? 4'h0
                         : start_age_r + {3'h0, start_age_r != 4'hF};
            if (busy && !busy_d_r) begin
                rise_cnt_r <= 6'h00;
            end else if (busy && conv_clk && !clk_d_r) begin
                rise_cnt_r <= rise_cnt_r + 6'h01;
            end
        end
    end

    sequence s_idle_start;
        $fell(convst_n) && !cs_n && !busy;
    endsequence
    sequence s_port_idle;
        (cs_n || rd_n) [*4];
    endsequence
    sequence s_port_read;
        (!cs_n && !rd_n) [*4];
    endsequence
    sequence s_high_lane;
        (byte_sel && !result_oe_n) [*4];
    endsequence
    sequence s_lane_held;
        ($stable(byte_sel) && !result_oe_n && !busy) [*4];
    endsequence

    a_start_busy_rise: assert property (s_idle_start |-> ##[2:6] busy)
        else $error("busy did not rise after a start");
    a_busy_has_start: assert property ($rose(busy) |-> start_age_r inside {[1:6]})
        else $error("busy rose without a selected start");
    a_busy_holds_on: assert property ($rose(busy) |=> busy [*8])
        else $error("busy dropped early");
    a_busy_fall_count: assert property ($fell(busy) |-> rise_cnt_r inside {[RISE_LO:RISE_HI]})
        else $error("wrong conversion clock count");
    a_busy_fall_edge: assert property ($fell(busy) |-> clk_age_r < BUSY_AGE)
        else $error("busy fell too late after clock rise");
    a_port_idle_off: assert property (s_port_idle |-> result_oe_n)
        else $error("bus driven without select and read");
    a_port_read_on: assert property (s_port_read |-> !result_oe_n)
        else $error("bus not driven during read");
    a_high_lane_low: assert property (s_high_lane |-> result_bus[7:0] == result_bus[15:8])
        else $error("high byte missing on low lane");
    a_lane_steady: assert property (s_lane_held |-> $stable(result_bus))
        else $error("read data moved while held");
    a_byte_setup: assert property ($fell(rd_n) |-> $stable(byte_sel))
        else $error("half select moved with the read strobe");
endmodule

// file: testbench/tb_top.sv
// self-checking bench: host and converter ends joined by the link pins
`timescale 1ns/1ps
module tb_top;
    import sar_pkg::*;

    typedef struct packed {
        logic                byte_mode;
        logic [RESULT_W-1:0] code;
    } sar_row_type;

    logic                core_clk;
    logic                rst;
    logic                start_req;
    logic                byte_mode;
    logic [RESULT_W-1:0] sample_code;
    logic                start_ready;
    logic                data_valid;
    logic                conv_done;
    logic [RESULT_W-1:0] data_word;
    logic [RESULT_W-1:0] result_word;
    logic                lo_seen;
    logic                hi_seen;
    logic                done_seen;
    int                  bad_count;
    int                  tests_run;
    int                  cyc;
    sar_row_type         rows [6];

    sar_link_if link ();

    // shortest legal conversion clock keeps one sample near 520 core cycles
    sar_dev #(.ACQ_N(ACQ_CYCLES), .CONV_N(CONV_CYCLES)) i_sar_dev (
        .core_clk, .rst, .link, .sample_code, .conv_done, .result_word);
    sar_host #(.CLK_DIV(13), .STROBE_CYC(4)) i_sar_host (
        .core_clk, .rst, .link, .start_req, .byte_mode, .start_ready, .data_valid, .data_word);
    sar_link_properties i_sar_link_properties (
        .core_clk, .rst, .convst_n(link.convst_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
        .byte_sel(link.byte_sel), .conv_clk(link.conv_clk), .busy(link.busy),
        .result_bus(link.result_bus), .result_oe_n(link.result_oe_n));

    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a hung handshake ends the run rather than stalling it
    task automatic guard();
        if (cyc >= 3000) begin
            bad_count++;
            complete_run();
        end
    endtask

    // holds start_req until the host takes it at a rising edge
    task automatic take_start();
        cyc = 0;
        while (start_ready !== 1'h1 && cyc < 3000) begin
            @(negedge core_clk);
            cyc++;
        end
        guard();
        @(negedge core_clk);
    endtask

    // waits for the next result, noting what the read lanes carried
    task automatic wait_valid(input sar_row_type r);
        lo_seen = 1'h0;
        hi_seen = 1'h0;
        done_seen = 1'h0;
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
            done_seen = done_seen | (conv_done === 1'h1);
            lo_seen = lo_seen | (link.result_oe_n === 1'h0 && link.byte_sel === 1'h0
                && link.result_bus[7:0] === r.code[7:0]
                && (r.byte_mode || link.result_bus[15:8] === r.code[15:8]));
            hi_seen = hi_seen | (link.result_oe_n === 1'h0 && link.byte_sel === 1'h1
                && link.result_bus[7:0] === r.code[15:8]);
        end while (data_valid !== 1'h1 && cyc < 3000);
        guard();
        check(data_word, r.code);
        check(result_word, r.code);
        check({15'h0000, done_seen}, 16'h0001);
        check({15'h0000, link.busy}, 16'h0000);
        check({15'h0000, lo_seen}, 16'h0001);
        if (r.byte_mode) check({15'h0000, hi_seen}, 16'h0001);
    endtask

    // the input is scrambled during acquisition: the held sample must win
    task automatic run_row(input sar_row_type r);
        byte_mode = r.byte_mode;
        sample_code = r.code;
        start_req = 1'h1;
        take_start();
        start_req = 1'h0;
        repeat (20) @(negedge core_clk);
        sample_code = ~r.code;
        wait_valid(r);
    endtask

    initial begin
        rst = 1'h1;
        start_req = 1'h0;
        byte_mode = 1'h0;
        sample_code = 16'h0000;
        bad_count = 0;
        tests_run = 0;
        rows = '{'{1'h0, 16'h7FFF}, '{1'h1, 16'h8000}, '{1'h0, 16'hA55A},
                 '{1'h1, 16'h12ED}, '{1'h1, 16'hFFFF}, '{1'h0, 16'h0001}};
        repeat (20) @(negedge core_clk);
        check({12'h000, link.busy, link.result_oe_n, link.convst_n, link.cs_n}, 16'h0007);
        rst = 1'h0;
        @(negedge core_clk);
        foreach (rows[i]) run_row(rows[i]);
        // start held high: the host must still space requests a sample period apart
        byte_mode = rows[3].byte_mode;
        sample_code = rows[3].code;
        start_req = 1'h1;
        take_start();
        take_start();
        check({15'h0000, cyc >= CORE_PER_SAMPLE - 1}, 16'h0001);
        start_req = 1'h0;
        wait_valid(rows[3]);
        // reset landing mid-conversion must quiet busy and the bus at once
        start_req = 1'h1;
        take_start();
        start_req = 1'h0;
        repeat (100) @(negedge core_clk);
        check({15'h0000, link.busy}, 16'h0001);
        rst = 1'h1;
        @(negedge core_clk);
        check({14'h0000, link.busy, link.result_oe_n}, 16'h0001);
        rst = 1'h0;
        @(negedge core_clk);
        run_row(rows[2]);
        complete_run();
    end
endmodule
